// ---- include/ddt_pkg.sv ----
`default_nettype none
package ddt_pkg;
    // register byte offsets
    localparam logic [7:0] DDT_CTRL0_OFS   = 8'h00;
    localparam logic [7:0] DDT_LOAD0_OFS   = 8'h04;
    localparam logic [7:0] DDT_BGLOAD0_OFS = 8'h08;
    localparam logic [7:0] DDT_VALUE0_OFS  = 8'h0c;
    localparam logic [7:0] DDT_CTRL1_OFS   = 8'h10;
    localparam logic [7:0] DDT_LOAD1_OFS   = 8'h14;
    localparam logic [7:0] DDT_BGLOAD1_OFS = 8'h18;
    localparam logic [7:0] DDT_VALUE1_OFS  = 8'h1c;
    localparam logic [7:0] DDT_STAT_OFS    = 8'h20;
    localparam logic [7:0] DDT_MASK_OFS    = 8'h24;
    localparam logic [7:0] DDT_ICLR_OFS    = 8'h28;
    // control field positions
    localparam int DDT_RUN_BIT    = 0;
    localparam int DDT_SHOT_BIT   = 1;
    localparam int DDT_WIDE_BIT   = 2;
    localparam int DDT_PER_BIT    = 3;
    localparam int DDT_PSC_LO     = 4;
    localparam int DDT_CTRL_W     = 6;
    // prescale select encodings
    typedef enum logic [1:0] {
        DDT_PSC_DIV1   = 2'b00,
        DDT_PSC_DIV16  = 2'b01,
        DDT_PSC_DIV256 = 2'b10
    } ddt_psc_t;
    // prescaler terminal counts
    localparam logic [7:0] DDT_TC_DIV1   = 8'h00;
    localparam logic [7:0] DDT_TC_DIV16  = 8'h0f;
    localparam logic [7:0] DDT_TC_DIV256 = 8'hff;
    // count limits and reset values
    localparam logic [31:0] DDT_MAX16    = 32'h0000ffff;
    localparam logic [31:0] DDT_MAX32    = 32'hffffffff;
    localparam logic [31:0] DDT_CNT_RST  = 32'h0000ffff;
    localparam logic [31:0] DDT_LOAD_RST = 32'h00000000;
    localparam logic [31:0] DDT_ZERO     = 32'h00000000;
    localparam logic [31:0] DDT_ONE      = 32'h00000001;
    localparam logic [5:0]  DDT_CTRL_RST = 6'h00;
endpackage
`default_nettype wire

// ---- hdl/ddt_timer_chan.sv ----
`timescale 1ns/100ps
`default_nettype none
module ddt_timer_chan
    import ddt_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        run,
    input  wire logic        single_shot_select,
    input  wire logic        wide_count_width,
    input  wire logic        periodic_reload_mode,
    input  wire logic [1:0]  psc_sel,
    input  wire logic        fg_we,
    input  wire logic        bg_we,
    input  wire logic [31:0] wdata,
    output logic      [31:0] count,
    output logic      [31:0] reload,
    output logic             zero_evt
);
    logic [7:0]  psc_cnt;       // prescale divider
    logic        stopped;       // single shot has expired
    logic [7:0]  psc_tc;        // selected terminal count
    logic        psc_hit;       // divider wraps this cycle
    logic        tick;          // one counting step
    logic [31:0] clamped;       // write data limited to width
    logic [31:0] width_max;     // all ones of current width
    logic [31:0] next_count;    // count after a step
    logic        hits_zero;     // step lands on zero

    // divide by 1, 16 or 256
    assign psc_tc = (psc_sel == DDT_PSC_DIV16)  ? DDT_TC_DIV16 :
                    (psc_sel == DDT_PSC_DIV256) ? DDT_TC_DIV256 : DDT_TC_DIV1;
    assign psc_hit = (psc_cnt >= psc_tc);
    // halted or expired timer does not step
    assign tick = run && !stopped && psc_hit;
    assign width_max = wide_count_width ? DDT_MAX32 : DDT_MAX16;
    assign clamped = (!wide_count_width && wdata > DDT_MAX16) ? DDT_MAX16 : wdata;
    // reload at zero: width maximum or period
    assign next_count = (count == DDT_ZERO)
                      ? (periodic_reload_mode ? reload : width_max)
                      : count - DDT_ONE;
    assign hits_zero = tick && (count == DDT_ONE);

    // prescaler, stops with the timer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            psc_cnt <= 8'h00;
        else if (clk_en && run && !stopped)
            psc_cnt <= psc_hit ? 8'h00 : psc_cnt + 8'h01;
    end

    // count and reload value
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count  <= DDT_CNT_RST;
            reload <= DDT_LOAD_RST;
        end
        else if (clk_en)
        begin
            if (fg_we)
            begin
                count  <= clamped;
                reload <= clamped;
            end
            else
            begin
                if (bg_we)
                    reload <= clamped;
                if (tick)
                    count <= next_count;
            end
        end
    end

    // single shot expiry and zero event
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stopped  <= 1'b0;
            zero_evt <= 1'b0;
        end
        else if (clk_en)
        begin
            zero_evt <= hits_zero && !fg_we;
            if (fg_we || !single_shot_select)
                stopped <= 1'b0;
            else if (hits_zero)
                stopped <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/ddt_top.sv ----
// How it works
// - prescale clock by 1, 16 or 256
// - count width 16 or 32 bits
// - free run reloads width maximum
// - periodic mode reloads programmed period
// - foreground write sets reload and count
// - 16-bit mode clamps loads to maximum
// - background write changes reload only
// - single shot stops at zero until reload
// - continuous mode reloads at every zero
// - halt keeps count and settings
// - status nonzero while interrupt pending
// - interrupt output gated by enable bit
// - software clear drops pending flag
// - two timer interrupts plus merged OR
`timescale 1ns/100ps
`default_nettype none
module ddt_top
    import ddt_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             first_timer_irq,
    output logic             second_timer_irq,
    output logic             merged_expiry_irq
);
    // per timer control registers
    logic [DDT_CTRL_W-1:0] ctrl [2];
    // interrupt pending flags
    logic [1:0]  pend;
    // interrupt enable bits
    logic [1:0]  mask;
    // per timer counter views
    logic [31:0] cnt_v [2];
    logic [31:0] rld_v [2];
    logic [1:0]  zero_evt;

    // bus phase decode
    wire         acc      = psel && penable && !pready;
    wire         done     = psel && penable && pready;
    wire         wr_done  = done && pwrite;
    wire         rd_done  = done && !pwrite;

    // address decode
    wire         hit_ctrl0   = (paddr == DDT_CTRL0_OFS);
    wire         hit_load0   = (paddr == DDT_LOAD0_OFS);
    wire         hit_bg0     = (paddr == DDT_BGLOAD0_OFS);
    wire         hit_val0    = (paddr == DDT_VALUE0_OFS);
    wire         hit_ctrl1   = (paddr == DDT_CTRL1_OFS);
    wire         hit_load1   = (paddr == DDT_LOAD1_OFS);
    wire         hit_bg1     = (paddr == DDT_BGLOAD1_OFS);
    wire         hit_val1    = (paddr == DDT_VALUE1_OFS);
    wire         hit_stat    = (paddr == DDT_STAT_OFS);
    wire         hit_mask    = (paddr == DDT_MASK_OFS);
    wire         hit_iclr    = (paddr == DDT_ICLR_OFS);
    wire         hit_any     = hit_ctrl0 | hit_load0 | hit_bg0 | hit_val0 |
                               hit_ctrl1 | hit_load1 | hit_bg1 | hit_val1 |
                               hit_stat  | hit_mask  | hit_iclr;

    // write strobes, taken at the completing edge
    wire [1:0]   ctrl_we  = {wr_done && hit_ctrl1, wr_done && hit_ctrl0};
    wire [1:0]   fg_we    = {wr_done && hit_load1, wr_done && hit_load0};
    wire [1:0]   bg_we    = {wr_done && hit_bg1,   wr_done && hit_bg0};
    wire         mask_we  = wr_done && hit_mask;
    wire         iclr_we  = wr_done && hit_iclr;
    wire         stat_rd  = rd_done && hit_stat;

    // flags to clear this cycle
    wire [1:0]   clr_bits = (stat_rd ? 2'b11 : 2'b00) |
                            (iclr_we ? pwdata[1:0] : 2'b00);

    // read data selection
    wire [31:0]  ctrl0_rd = {26'h0000000, ctrl[0]};
    wire [31:0]  ctrl1_rd = {26'h0000000, ctrl[1]};
    wire [31:0]  rd_mux   = hit_ctrl0 ? ctrl0_rd :
                            (hit_load0 || hit_bg0) ? rld_v[0] :
                            hit_val0  ? cnt_v[0] :
                            hit_ctrl1 ? ctrl1_rd :
                            (hit_load1 || hit_bg1) ? rld_v[1] :
                            hit_val1  ? cnt_v[1] :
                            hit_stat  ? {30'h00000000, pend} :
                            hit_mask  ? {30'h00000000, mask} :
                            32'h00000000;

    // next interrupt state, set wins over clear
    wire [1:0]   next_pend = (pend & ~clr_bits) | zero_evt;
    wire [1:0]   next_irq  = next_pend & mask;

    // the two timer channels
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : gen_chan
            // control register of this timer
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    ctrl[g] <= DDT_CTRL_RST;
                else if (clk_en && ctrl_we[g])
                    ctrl[g] <= pwdata[DDT_CTRL_W-1:0];
            end

            ddt_timer_chan u_chan (
                .pclk                 (pclk),
                .presetn              (presetn),
                .clk_en               (clk_en),
                .run                  (ctrl[g][DDT_RUN_BIT]),
                .single_shot_select   (ctrl[g][DDT_SHOT_BIT]),
                .wide_count_width     (ctrl[g][DDT_WIDE_BIT]),
                .periodic_reload_mode (ctrl[g][DDT_PER_BIT]),
                .psc_sel              (ctrl[g][DDT_PSC_LO+1:DDT_PSC_LO]),
                .fg_we                (fg_we[g]),
                .bg_we                (bg_we[g]),
                .wdata                (pwdata),
                .count                (cnt_v[g]),
                .reload               (rld_v[g]),
                .zero_evt             (zero_evt[g])
            );
        end
    endgenerate

    // bus answer: one wait cycle, then ready
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else if (clk_en)
        begin
            pready <= acc;
            if (acc)
            begin
                pslverr <= !hit_any;
                prdata  <= pwrite ? 32'h00000000 : rd_mux;
            end
            else
            begin
                pslverr <= 1'b0;
            end
        end
    end

    // interrupt enables
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask <= 2'b00;
        else if (clk_en && mask_we)
            mask <= pwdata[1:0];
    end

    // pending flags and registered interrupt lines
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend              <= 2'b00;
            first_timer_irq   <= 1'b0;
            second_timer_irq  <= 1'b0;
            merged_expiry_irq <= 1'b0;
        end
        else if (clk_en)
        begin
            pend              <= next_pend;
            first_timer_irq   <= next_irq[0];
            second_timer_irq  <= next_irq[1];
            merged_expiry_irq <= |next_irq;
        end
    end
endmodule
`default_nettype wire

// ---- verification/ddt_top_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module ddt_top_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        clk_en,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        first_timer_irq,
    input wire logic        second_timer_irq,
    input wire logic        merged_expiry_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // merged line follows the two timer lines
    property p_merge; merged_expiry_irq == (first_timer_irq || second_timer_irq); endproperty
    a_merge: assert property (p_merge) else $error("merged irq is not the or of both");
    // answer only after an access phase
    property p_rdy; pready |-> $past(psel && penable); endproperty
    a_rdy: assert property (p_rdy) else $error("pready without access");
    // answer is a one cycle pulse
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready held too long");
    // error only with the answer
    property p_errrdy; pslverr |-> pready; endproperty
    a_errrdy: assert property (p_errrdy) else $error("pslverr without pready");
    // answer in the second access cycle
    property p_ans; $rose(penable) && psel && clk_en |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("late bus answer");
    // unmapped place answers error and zero data
    property p_unmap; $rose(penable) && psel && clk_en && paddr > 8'h28 |=> pslverr && prdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
    // pending stays until software touches the bus
    property p_hold0; first_timer_irq && !psel && !$past(psel) |=> first_timer_irq; endproperty
    a_hold0: assert property (p_hold0) else $error("first irq dropped alone");
    property p_hold1; second_timer_irq && !psel && !$past(psel) |=> second_timer_irq; endproperty
    a_hold1: assert property (p_hold1) else $error("second irq dropped alone");
    c_err: cover property (pready && pslverr);
    c_irq0: cover property ($rose(first_timer_irq));
    c_irq1: cover property ($rose(second_timer_irq));
endmodule
bind ddt_top ddt_top_chk i_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .first_timer_irq(first_timer_irq),
    .second_timer_irq(second_timer_irq), .merged_expiry_irq(merged_expiry_irq));
`default_nettype wire

// ---- verification/dual_down_counter_timer_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module dual_down_counter_timer_test;
    import ddt_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, err, irq0, irq1, irqm, pready, pslverr, ce;
    logic [7:0]  paddr, b;
    logic [31:0] pwdata, prdata, rd, v, prev;
    int          error_cnt, cmp_count, k, f;
    ddt_top i_dut (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .first_timer_irq(irq0), .second_timer_irq(irq1), .merged_expiry_irq(irqm));
    // 40 mhz clock
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) error_cnt++;
        if (got !== exp) $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    endtask
    // verdict and end of run
    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 40);
        if (n >= 40) error_cnt++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // expected load after width limit
    function automatic logic [31:0] clamp(input logic [31:0] x, input logic wide);
        return (wide || x <= DDT_MAX16) ? x : DDT_MAX16;
    endfunction
    // watchdog
    initial
    begin
        #1000000;
        error_cnt++;
        results();
    end
    initial
    begin
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; presetn = 0; error_cnt = 0; cmp_count = 0;
        ce = 1'b1;
        v = $urandom(32'hf37d);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rchk(DDT_VALUE0_OFS, DDT_CNT_RST);
        rchk(DDT_CTRL1_OFS, 32'(DDT_CTRL_RST));
        rchk(8'h40, 32'h0);
        chk(32'(err), 32'h1);
        $display("reset test done");
        // random loads, both widths, foreground and background
        for (int i = 0; i < 8; i++)
        begin
            v = (i == 0) ? 32'h00010000 : $urandom();
            apb(1'b1, DDT_CTRL0_OFS, 32'(i[0]) << DDT_WIDE_BIT);
            apb(1'b0, DDT_VALUE0_OFS, 32'h0);
            prev = rd;
            apb(1'b1, i[1] ? DDT_BGLOAD0_OFS : DDT_LOAD0_OFS, v);
            rchk(DDT_LOAD0_OFS, clamp(v, i[0]));
            rchk(DDT_VALUE0_OFS, i[1] ? prev : clamp(v, i[0]));
        end
        $display("load test done");
        // single shot expiry per timer and prescale
        for (int t = 0; t < 2; t++)
        for (int p = 0; p < 3; p++)
        begin
            b = 8'(t * 16);
            f = (p == 0) ? 1 : (p == 1) ? 16 : 256;
            apb(1'b1, DDT_MASK_OFS, 32'(1 << t));
            // halt first, so the old setting cannot count the new load down
            apb(1'b1, b + DDT_CTRL0_OFS, 32'h0);
            apb(1'b1, b + DDT_LOAD0_OFS, 32'h4);
            apb(1'b1, b + DDT_CTRL0_OFS, (32'(p) << DDT_PSC_LO) | 32'h3);
            k = 0;
            while (irqm !== 1'b1 && k < 6 * f + 20) begin @(posedge pclk); k++; end
            chk(32'(k >= 3 * f && k <= 5 * f + 8), 32'h1);
            chk({30'h0, irq1, irq0}, 32'(1 << t));
            rchk(b + DDT_VALUE0_OFS, 32'h0);
            rchk(DDT_STAT_OFS, 32'(1 << t));
            rchk(DDT_STAT_OFS, 32'h0);
            chk(32'(irqm), 32'h0);
        end
        $display("expiry test done");
        // free run reload, masked event, halt
        apb(1'b1, DDT_MASK_OFS, 32'h0);
        apb(1'b1, DDT_LOAD1_OFS, 32'h2);
        apb(1'b1, DDT_CTRL1_OFS, 32'h1);
        apb(1'b1, DDT_CTRL1_OFS, 32'h0);
        apb(1'b0, DDT_VALUE1_OFS, 32'h0);
        v = rd;
        chk(32'(v >= 32'hffe0 && v <= DDT_MAX16), 32'h1);
        chk(32'(irq1), 32'h0);
        rchk(DDT_VALUE1_OFS, v);
        rchk(DDT_STAT_OFS, 32'h2);
        // periodic reload keeps to the period
        apb(1'b1, DDT_LOAD1_OFS, 32'h3);
        apb(1'b1, DDT_CTRL1_OFS, 32'h9);
        apb(1'b1, DDT_CTRL1_OFS, 32'h8);
        apb(1'b0, DDT_VALUE1_OFS, 32'h0);
        chk(32'(rd <= 32'h3), 32'h1);
        // the period run set timer1 pending: clear it by write one
        apb(1'b1, DDT_ICLR_OFS, 32'h2);
        rchk(DDT_STAT_OFS, 32'h0);
        // wide free run reloads the 32 bit maximum
        apb(1'b1, DDT_LOAD1_OFS, 32'h1);
        apb(1'b1, DDT_CTRL1_OFS, 32'h5);
        apb(1'b1, DDT_CTRL1_OFS, 32'h4);
        apb(1'b0, DDT_VALUE1_OFS, 32'h0);
        chk(32'(rd >= 32'hffffffe0), 32'h1);
        // clock enable low freezes the count for twenty cycles
        apb(1'b1, DDT_CTRL1_OFS, 32'h5);
        @(posedge pclk);
        ce <= 1'b0;
        repeat (20) @(posedge pclk);
        ce <= 1'b1;
        apb(1'b1, DDT_CTRL1_OFS, 32'h4);
        apb(1'b0, DDT_VALUE1_OFS, 32'h0);
        chk(32'(rd >= 32'hfffffff0 && rd < 32'hfffffffd), 32'h1);
        $display("reload test done");
        results();
    end
endmodule
`default_nettype wire
